/* File: icst_capture.sv */
// Input capture unit with its own 16-bit counter, four-entry capture FIFO,
// sync/trigger mode control, cascade support and sticky interrupts.
// Assumes a single 40 MHz clock; clock sources and sync sources arrive as
// asynchronous levels and are synchronised here.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Function
// - Free-run counter counts up and wraps
// - Capture event stores current counter value
// - FIFO holds four captured values
// - Sync mode captures, sync event clears counter
// - Trigger mode holds counter until sync event
// - Sync field zero, trigger bit clear: free-run
// - Non-zero sync field selects sync/trigger source
// - Trigger bit picks trigger versus synchronous
// - Zero field, trigger bit: software trigger status
// - Up to thirty selectable sync sources
// - Two units cascade into 32-bit capture
// - Six selectable clock sources per unit
// - Free-run period follows selected clock source
module icst_capture (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Capture pin and sources
  input wire logic capture_input_pin_in,
  input wire logic [5:0] clk_src_in,
  input wire logic [29:0] sync_src_in,
  // Cascade link to the adjacent unit, and the capture pulse
  input wire logic cascade_carry_in,
  output logic carry_out,
  output logic capture_pulse_out,
  // Interrupt
  output logic irq_out
);

  logic [15:0] ctrl1_reg;
  logic [15:0] ctrl2_reg;
  logic [15:0] capture_counter;
  logic [15:0] fifo_mem_reg [0:3];
  logic [1:0] wr_ptr_reg;
  logic [1:0] rd_ptr_reg;
  logic [2:0] fill_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic pin_level;
  logic pin_prev_reg;
  logic [5:0] clk_level;
  logic [29:0] sync_level;
  logic clk_prev_reg;
  logic sync_prev_reg;
  logic running_reg;
  logic tick;
  logic sync_evt;
  logic cap_evt;
  logic fifo_pop;
  logic fifo_push;
  logic sync_sel_lvl;
  logic clk_sel_lvl;
  logic cap_take;

  icst_pkg::icst_mode_e mode;
  logic [4:0] sync_sel;
  logic [2:0] clk_sel;
  logic [1:0] edge_sel;
  logic enable;
  logic cascade;

  assign sync_sel = ctrl2_reg[icst_pkg::C2_SYNC_LSB +: 5];
  assign clk_sel = ctrl1_reg[icst_pkg::C1_CLKSEL_LSB +: 3];
  assign edge_sel = ctrl1_reg[icst_pkg::C1_EDGE_LSB +: 2];
  assign enable = ctrl1_reg[icst_pkg::C1_EN_BIT];
  assign cascade = ctrl1_reg[icst_pkg::C1_CASCADE_BIT];

  // Mode decode from the sync field and the trigger-mode bit.
  assign mode = (sync_sel == icst_pkg::SYNC_NONE) ?
    (ctrl2_reg[icst_pkg::C2_TRIGMODE_BIT] ? icst_pkg::ICST_SOFT : icst_pkg::ICST_FREE) :
    (ctrl2_reg[icst_pkg::C2_TRIGMODE_BIT] ? icst_pkg::ICST_TRIG : icst_pkg::ICST_SYNC);

  // Capture pin, clock sources and sync sources all come from outside.
  icst_pin_sync icst_pin_sync_i (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .async_in(capture_input_pin_in),
    .level_out(pin_level)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_clk
      icst_pin_sync icst_pin_sync_i (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .async_in(clk_src_in[gi]),
        .level_out(clk_level[gi])
      );
    end
    for (gi = 0; gi < 30; gi++)
    begin : g_sync
      icst_pin_sync icst_pin_sync_i (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .async_in(sync_src_in[gi]),
        .level_out(sync_level[gi])
      );
    end
  endgenerate

  // Source 0 of the clock select is the system clock itself; 1..6 pick an input.
  assign clk_sel_lvl = (clk_sel != 3'h0 && clk_sel <= 3'h6) ? clk_level[clk_sel - 3'h1] : 1'b0;

  assign sync_sel_lvl = (sync_sel != icst_pkg::SYNC_NONE && sync_sel <= 5'h1E) ?
    sync_level[sync_sel - 5'h01] : 1'b0;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      clk_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      clk_prev_reg <= clk_sel_lvl;
      sync_prev_reg <= sync_sel_lvl;
      pin_prev_reg <= pin_level;
    end
  end

  // In cascade mode the upper unit counts on the lower unit's carry.
  assign tick = enable && (cascade ? cascade_carry_in :
                ((clk_sel == 3'h0) ? 1'b1 : (clk_sel_lvl && !clk_prev_reg)));
  assign sync_evt = sync_sel_lvl && !sync_prev_reg;

  always_comb
  begin
    case (edge_sel)
      icst_pkg::EDGE_RISE: cap_evt = pin_level && !pin_prev_reg;
      icst_pkg::EDGE_FALL: cap_evt = !pin_level && pin_prev_reg;
      icst_pkg::EDGE_BOTH: cap_evt = pin_level != pin_prev_reg;
      default: cap_evt = 1'b0;
    endcase
  end

  // Trigger and software-trigger modes gate the counter with the trigger status.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      running_reg <= 1'b0;
    end
    else
    begin
      running_reg <= ctrl2_reg[icst_pkg::C2_TRIGGER_STATUS_BIT_BIT];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      capture_counter <= icst_pkg::COUNT_RESET;
      carry_out <= 1'b0;
    end
    else
    begin
      carry_out <= 1'b0;
      case (mode)
        icst_pkg::ICST_FREE:
        begin
          if (tick)
          begin
            capture_counter <= capture_counter + 16'h0001;
            carry_out <= (capture_counter == icst_pkg::COUNT_MAX);
          end
        end
        icst_pkg::ICST_SYNC:
        begin
          if (sync_evt)
          begin
            capture_counter <= icst_pkg::COUNT_RESET;
          end
          else if (tick)
          begin
            capture_counter <= capture_counter + 16'h0001;
            carry_out <= (capture_counter == icst_pkg::COUNT_MAX);
          end
        end
        icst_pkg::ICST_TRIG, icst_pkg::ICST_SOFT:
        begin
          if (running_reg && tick)
          begin
            capture_counter <= capture_counter + 16'h0001;
            carry_out <= (capture_counter == icst_pkg::COUNT_MAX);
          end
        end
        default: capture_counter <= capture_counter;
      endcase
    end
  end

  // Trigger modes take no captures until the trigger status is set, so no stale value is buffered.
  assign cap_take = enable && cap_evt && (mode == icst_pkg::ICST_FREE || mode == icst_pkg::ICST_SYNC ||
    ctrl2_reg[icst_pkg::C2_TRIGGER_STATUS_BIT_BIT]);
  assign fifo_push = cap_take && (fill_reg != 3'(icst_pkg::FIFO_DEPTH));
  assign fifo_pop = rd_in && (addr_in == icst_pkg::OFS_FIFO) && (fill_reg != 3'h0);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      capture_pulse_out <= 1'b0;
    end
    else
    begin
      capture_pulse_out <= cap_take;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (fifo_push)
    begin
      fifo_mem_reg[wr_ptr_reg] <= capture_counter;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      fill_reg <= 3'h0;
    end
    else
    begin
      if (fifo_push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      end
      if (fifo_pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
      fill_reg <= fill_reg + {2'h0, fifo_push} - {2'h0, fifo_pop};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ctrl1_reg <= icst_pkg::CTRL1_RESET;
    end
    else if (wr_in && addr_in == icst_pkg::OFS_CTRL1)
    begin
      ctrl1_reg <= wdata_in;
    end
  end

  // A sync event in trigger mode sets the trigger status; software may also set or clear it.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ctrl2_reg <= icst_pkg::CTRL2_RESET;
    end
    else
    begin
      if (wr_in && addr_in == icst_pkg::OFS_CTRL2)
      begin
        ctrl2_reg <= wdata_in;
      end
      if (mode == icst_pkg::ICST_TRIG && sync_evt)
      begin
        ctrl2_reg[icst_pkg::C2_TRIGGER_STATUS_BIT_BIT] <= 1'b1;
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle keeps its bit set.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      irq_stat_reg <= 2'h0;
    end
    else
    begin
      if (wr_in && addr_in == icst_pkg::OFS_IRQ_STAT)
      begin
        irq_stat_reg <= irq_stat_reg & ~wdata_in[1:0];
      end
      if (fifo_push)
      begin
        irq_stat_reg[icst_pkg::IRQ_CAPTURE_BIT] <= 1'b1;
      end
      if (cap_take && !fifo_push)
      begin
        irq_stat_reg[icst_pkg::IRQ_OVERFLOW_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      irq_mask_reg <= icst_pkg::IRQ_MASK_RESET;
    end
    else if (wr_in && addr_in == icst_pkg::OFS_IRQ_MASK)
    begin
      irq_mask_reg <= wdata_in[1:0];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Reading the FIFO when empty returns zero and pops nothing.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rdata_out <= 16'h0000;
    end
    else if (rd_in)
    begin
      case (addr_in)
        icst_pkg::OFS_CTRL1: rdata_out <= ctrl1_reg;
        icst_pkg::OFS_CTRL2: rdata_out <= ctrl2_reg;
        icst_pkg::OFS_FIFO: rdata_out <= (fill_reg != 3'h0) ? fifo_mem_reg[rd_ptr_reg] : 16'h0000;
        icst_pkg::OFS_STATUS: rdata_out <= {11'h000, mode, fill_reg};
        icst_pkg::OFS_IRQ_STAT: rdata_out <= {14'h0000, irq_stat_reg};
        icst_pkg::OFS_IRQ_MASK: rdata_out <= {14'h0000, irq_mask_reg};
        icst_pkg::OFS_COUNT: rdata_out <= capture_counter;
        default: rdata_out <= 16'h0000;
      endcase
    end
    else
    begin
      rdata_out <= 16'h0000;
    end
  end

endmodule : icst_capture

/* File: icst_pkg.sv */
// Package for the input capture unit: register offsets, field positions,
// reset values and mode encodings.
// Assumes a single 40 MHz clock domain and the plain register port.
package icst_pkg;

  localparam int unsigned CLK_MHZ = 40;

  // Register offsets.
  localparam logic [3:0] OFS_CTRL1 = 4'h0;
  localparam logic [3:0] OFS_CTRL2 = 4'h1;
  localparam logic [3:0] OFS_FIFO = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
  localparam logic [3:0] OFS_COUNT = 4'h6;
  localparam logic [3:0] OFS_SYNC_SRC = 4'h7;

  // First control register fields.
  localparam int unsigned C1_EN_BIT = 0;
  localparam int unsigned C1_CLKSEL_LSB = 1;
  localparam int unsigned C1_EDGE_LSB = 4;
  localparam int unsigned C1_CASCADE_BIT = 6;

  // Second control register fields.
  localparam int unsigned C2_SYNC_LSB = 0;
  localparam int unsigned C2_TRIGGER_STATUS_BIT_BIT = 6;
  localparam int unsigned C2_TRIGMODE_BIT = 7;

  // Interrupt status bits.
  localparam int unsigned IRQ_CAPTURE_BIT = 0;
  localparam int unsigned IRQ_OVERFLOW_BIT = 1;

  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [15:0] CTRL2_RESET = 16'h0000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned NUM_CLK_SRC = 6;
  localparam int unsigned NUM_SYNC_SRC = 30;
  localparam logic [4:0] SYNC_NONE = 5'h00;

  // Edge modes for the capture input.
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [1:0] {
    ICST_FREE,
    ICST_SYNC,
    ICST_TRIG,
    ICST_SOFT
  } icst_mode_e;

endpackage : icst_pkg

/* File: icst_pin_sync.sv */
// Three-stage synchroniser for one asynchronous level input.
// Assumes clk_in is the only clock; the output changes once stages two and three agree.
`timescale 1ns/1ps
module icst_pin_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Level in and out
  input wire logic async_in,
  output logic level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        level_out <= s3_reg;
      end
    end
  end

endmodule : icst_pin_sync

/* File: icst_capture_sva.sv */
// Checker for the capture unit, bound to the ports of its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module icst_capture_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  // Pin and events
  input wire logic capture_input_pin_in,
  input wire logic carry_out,
  input wire logic capture_pulse_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  logic [1:0] mask_reg;
  logic pin_d_reg;
  logic [3:0] pin_age_reg;
  // The mask is shadowed from bus writes, so the interrupt can be judged from the ports alone.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      mask_reg <= 2'h0;
    else if (wr_in && addr_in == icst_pkg::OFS_IRQ_MASK)
      mask_reg <= wdata_in[1:0];
  end
  // Cycles since the pin last moved; saturates so a quiet pin never looks fresh.
  always_ff @(posedge clk_in)
  begin
    pin_d_reg <= capture_input_pin_in;
    if (srst_in)
      pin_age_reg <= 4'hF;
    else if (capture_input_pin_in != pin_d_reg)
      pin_age_reg <= 4'h0;
    else if (pin_age_reg != 4'hF)
      pin_age_reg <= pin_age_reg + 4'h1;
  end
  property p_rdata_idle;
    !$past(rd_in) |-> rdata_out == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");
  property p_fill_max;
    $past(rd_in) && $past(addr_in) == icst_pkg::OFS_STATUS |-> rdata_out[2:0] <= 3'h4;
  endproperty
  a_fill_max: assert property (p_fill_max)
    else $error("fill level above four");
  property p_carry_one;
    carry_out |=> !carry_out [*8];
  endproperty
  a_carry_one: assert property (p_carry_one)
    else $error("wrap pulse too long or too frequent");
  property p_mask_off;
    $past(wr_in) && $past(addr_in) == icst_pkg::OFS_IRQ_MASK && $past(wdata_in[1:0]) == 2'h0
      |=> !irq_out;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high after mask cleared");
  property p_irq_mask;
    irq_out |-> $past(mask_reg) != 2'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt high with all sources masked");
  property p_irq_cap;
    $rose(capture_pulse_out) && mask_reg[0] |-> ##[0:3] irq_out;
  endproperty
  a_irq_cap: assert property (p_irq_cap)
    else $error("unmasked capture gave no interrupt");
  property p_pulse_one;
    capture_pulse_out |=> !capture_pulse_out;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("one pin edge captured twice");
  property p_pulse_pin;
    capture_pulse_out |-> pin_age_reg >= 4'h1 && pin_age_reg <= 4'hA;
  endproperty
  a_pulse_pin: assert property (p_pulse_pin)
    else $error("capture without a recent pin edge");
  c_wrap: cover property (carry_out);
  c_capture: cover property (capture_pulse_out);
  c_irq: cover property ($rose(irq_out));
endmodule : icst_capture_sva

/* File: icst_src_model.sv */
// Far-side model: capture pin, external clock sources and sync sources.
// Assumes clk_in is the bench clock; every task first waits for its next rising edge.
`timescale 1ns/1ps
module icst_src_model (
  // Clock
  input wire logic clk_in,
  // Sources
  output logic capture_input_pin_out,
  output logic [5:0] clk_src_out,
  output logic [29:0] sync_src_out
);
  initial
  begin
    capture_input_pin_out = 1'h0;
    clk_src_out = 6'h00;
    sync_src_out = 30'h00000000;
  end
  // Each level is held well past the synchroniser depth so no edge is lost.
  task automatic pin_toggle();
    @(posedge clk_in);
    capture_input_pin_out <= ~capture_input_pin_out;
    repeat (8) @(posedge clk_in);
  endtask : pin_toggle
  task automatic clk_edges(input int n, input int k);
    @(posedge clk_in);
    repeat (k)
    begin
      clk_src_out[n] <= 1'h1;
      repeat (4) @(posedge clk_in);
      clk_src_out[n] <= 1'h0;
      repeat (4) @(posedge clk_in);
    end
  endtask : clk_edges
  // Select code n drives source line n-1.
  task automatic sync_pulse(input int n);
    @(posedge clk_in);
    sync_src_out[n - 1] <= 1'h1;
    repeat (4) @(posedge clk_in);
    sync_src_out[n - 1] <= 1'h0;
    repeat (8) @(posedge clk_in);
  endtask : sync_pulse
endmodule : icst_src_model

/* File: icst_capture_tb_top.sv */
// Self-checking bench for the capture unit, driven through its register port.
// Assumes the far-side model and the checker are compiled alongside.
`timescale 1ns/1ps
module icst_capture_tb_top;
  logic clk_in = 1'h0;
  logic srst_in = 1'h1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'h0;
  logic rd_in = 1'h0;
  logic cascade_carry_in = 1'h0;
  logic [15:0] rdata_out;
  logic capture_input_pin_in;
  logic [5:0] clk_src_in;
  logic [29:0] sync_src_in;
  logic carry_out;
  logic capture_pulse_out;
  logic irq_out;
  logic [15:0] c0;
  logic [15:0] c1;
  int fails = 0;
  int n_tests = 0;
  int k;
  always #12.5 clk_in = ~clk_in;
  icst_capture icst_capture_i (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .capture_input_pin_in(capture_input_pin_in),
    .clk_src_in(clk_src_in), .sync_src_in(sync_src_in), .cascade_carry_in(cascade_carry_in),
    .carry_out(carry_out), .capture_pulse_out(capture_pulse_out), .irq_out(irq_out));
  icst_src_model icst_src_model_i (.clk_in(clk_in), .capture_input_pin_out(capture_input_pin_in),
    .clk_src_out(clk_src_in), .sync_src_out(sync_src_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'h1;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 v = rdata_out;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rc
  task automatic runs(input logic exp);
    rd(icst_pkg::OFS_COUNT, c0);
    rd(icst_pkg::OFS_COUNT, c1);
    chk({15'h0000, c1 !== c0}, {15'h0000, exp});
  endtask : runs
  task automatic test_done();
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // The wrap alone takes about 65536 cycles; the rest needs well under a thousand.
  initial
  begin
    repeat (95000) @(posedge clk_in);
    fails++;
    test_done();
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'h0;
    rc(icst_pkg::OFS_CTRL1, icst_pkg::CTRL1_RESET);
    rc(icst_pkg::OFS_CTRL2, icst_pkg::CTRL2_RESET);
    rc(icst_pkg::OFS_COUNT, icst_pkg::COUNT_RESET);
    rc(icst_pkg::OFS_STATUS, {11'h000, icst_pkg::ICST_FREE, 3'h0});
    wr(4'hF, 16'hFFFF);
    rc(4'hF, 16'h0000);
    for (int n = 1; n <= icst_pkg::NUM_CLK_SRC; n++)
    begin
      wr(icst_pkg::OFS_CTRL1, 16'(1 + 2 * n));
      rd(icst_pkg::OFS_COUNT, c0);
      icst_src_model_i.clk_edges(n - 1, n);
      rd(icst_pkg::OFS_COUNT, c1);
      chk(c1 - c0, 16'(n));
    end
    // Counter stepped by hand from source one, so every capture has a known value.
    wr(icst_pkg::OFS_CTRL1, {10'h000, icst_pkg::EDGE_BOTH, 4'h3});
    rd(icst_pkg::OFS_COUNT, c0);
    for (int i = 0; i < 5; i++)
    begin
      icst_src_model_i.pin_toggle();
      icst_src_model_i.clk_edges(0, 1);
    end
    rc(icst_pkg::OFS_STATUS, {11'h000, icst_pkg::ICST_FREE, 3'h4});
    rc(icst_pkg::OFS_IRQ_STAT, 16'h0003);
    wr(icst_pkg::OFS_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge clk_in);
    chk({15'h0000, irq_out}, 16'h0001);
    for (int i = 0; i < 4; i++)
      rc(icst_pkg::OFS_FIFO, c0 + 16'(i));
    rc(icst_pkg::OFS_FIFO, 16'h0000);
    wr(icst_pkg::OFS_CTRL1, {10'h000, icst_pkg::EDGE_FALL, 4'h3});
    icst_src_model_i.pin_toggle();
    icst_src_model_i.clk_edges(0, 1);
    icst_src_model_i.pin_toggle();
    wr(icst_pkg::OFS_CTRL1, {10'h000, icst_pkg::EDGE_RISE, 4'h3});
    icst_src_model_i.pin_toggle();
    icst_src_model_i.pin_toggle();
    rc(icst_pkg::OFS_FIFO, c0 + 16'h0005);
    rc(icst_pkg::OFS_FIFO, c0 + 16'h0006);
    wr(icst_pkg::OFS_IRQ_STAT, 16'h0003);
    rc(icst_pkg::OFS_IRQ_STAT, 16'h0000);
    wr(icst_pkg::OFS_IRQ_MASK, 16'h0000);
    wr(icst_pkg::OFS_CTRL1, 16'h0041);
    rd(icst_pkg::OFS_COUNT, c0);
    repeat (3)
    begin
      @(posedge clk_in);
      cascade_carry_in <= 1'h1;
      @(posedge clk_in);
      cascade_carry_in <= 1'h0;
    end
    rd(icst_pkg::OFS_COUNT, c1);
    chk(c1 - c0, 16'h0003);
    wr(icst_pkg::OFS_CTRL1, 16'h0001);
    for (k = 0; k < 70000 && carry_out !== 1'h1; k++)
      @(posedge clk_in) #1;
    chk({15'h0000, carry_out}, 16'h0001);
    rd(icst_pkg::OFS_COUNT, c1);
    chk({15'h0000, c1 < 16'h0008}, 16'h0001);
    wr(icst_pkg::OFS_CTRL2, 16'h0003);
    rc(icst_pkg::OFS_STATUS, {11'h000, icst_pkg::ICST_SYNC, 3'h0});
    repeat (100) @(posedge clk_in);
    rd(icst_pkg::OFS_COUNT, c0);
    icst_src_model_i.sync_pulse(2);
    rd(icst_pkg::OFS_COUNT, c1);
    chk({15'h0000, c1 > c0}, 16'h0001);
    icst_src_model_i.sync_pulse(3);
    rd(icst_pkg::OFS_COUNT, c1);
    chk({15'h0000, c1 < 16'h0020}, 16'h0001);
    wr(icst_pkg::OFS_CTRL2, 16'h0085);
    rc(icst_pkg::OFS_STATUS, {11'h000, icst_pkg::ICST_TRIG, 3'h0});
    runs(1'h0);
    icst_src_model_i.sync_pulse(5);
    rc(icst_pkg::OFS_CTRL2, 16'h00C5);
    runs(1'h1);
    wr(icst_pkg::OFS_CTRL2, 16'h0080);
    rc(icst_pkg::OFS_STATUS, {11'h000, icst_pkg::ICST_SOFT, 3'h0});
    runs(1'h0);
    repeat (2) icst_src_model_i.pin_toggle();
    rc(icst_pkg::OFS_STATUS, {11'h000, icst_pkg::ICST_SOFT, 3'h0});
    wr(icst_pkg::OFS_CTRL2, 16'h00C0);
    runs(1'h1);
    repeat (2) icst_src_model_i.pin_toggle();
    rc(icst_pkg::OFS_STATUS, {11'h000, icst_pkg::ICST_SOFT, 3'h1});
    test_done();
  end
endmodule : icst_capture_tb_top
bind icst_capture icst_capture_sva icst_capture_sva_i (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .capture_input_pin_in(capture_input_pin_in), .carry_out(carry_out),
  .capture_pulse_out(capture_pulse_out), .irq_out(irq_out));
